// ### test/pdv_host.sv
`timescale 1ns/100ps
module pdv_host (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    initial {addr, wdata, wr, rd} = 18'h0;
    // idle address and data are inverted so a stale value never looks valid
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk);
        {addr, wdata, wr} = {~a, ~d, 1'b0};
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        {addr, rd} = {~a, 1'b0};
        d = rvalid ? rdata : 8'hXX;
    endtask
endmodule

// ### test/pdv_regs_props.sv
`timescale 1ns/100ps
module pdv_regs_props (
    input wire logic        SYS_CLK,
    input wire logic        SRST,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        CORE_OVERRIDE,
    input wire logic        BAND_OVERRIDE,
    input wire logic [1:0]  CAL_CORE,
    input wire logic [7:0]  CAL_BAND,
    input wire logic        AUTO_CALIBRATION_ENABLE,
    input wire logic        REFERENCE_DOUBLER_SELECT,
    input wire logic [3:0]  CAL_CLOCK_DIVIDER,
    input wire logic [3:0]  OUTPUT_DIVIDER_SELECT,
    input wire logic [11:0] FEEDBACK_DIVIDE,
    input wire logic [1:0]  VCO_CORE,
    input wire logic [7:0]  VCO_BAND
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    wire w10 = REG_WR && REG_ADDR == 8'h10;
    wire w11 = REG_WR && REG_ADDR == 8'h11;
    wire w12 = REG_WR && REG_ADDR == 8'h12;
    AST_CTRL:
    assert property (w11 |=> {AUTO_CALIBRATION_ENABLE, REFERENCE_DOUBLER_SELECT} == $past(REG_WDATA[7:6]))
        else $error("control bits wrong");
    AST_CALDIV:
    assert property (w11 |-> ##2 CAL_CLOCK_DIVIDER == 4'h1 << $past(REG_WDATA[5:4], 2)) else $error("cal ratio");
    AST_FBHOLD:
    assert property (!w10 |=> $stable(FEEDBACK_DIVIDE)) else $error("divide changed without commit");
    AST_FBLOW:
    assert property (w10 |=> FEEDBACK_DIVIDE[7:0] == $past(REG_WDATA)) else $error("low byte wrong");
    AST_FBHIGH:
    assert property (w11 ##1 !w11 ##1 w10 |=> FEEDBACK_DIVIDE[11:8] == $past(REG_WDATA[3:0], 3))
        else $error("top nibble wrong");
    AST_OUTDIV:
    assert property (w12 |-> ##2 OUTPUT_DIVIDER_SELECT == 4'h1 << $past(REG_WDATA[7:6], 2)) else $error("out ratio");
    AST_CORE:
    assert property (!CORE_OVERRIDE |=> VCO_CORE == $past(CAL_CORE)) else $error("core not from cal");
    AST_BAND:
    assert property (!BAND_OVERRIDE |=> VCO_BAND == $past(CAL_BAND)) else $error("band not from cal");
    cover property (w11 ##2 w10);
    cover property (w12);
    cover property (CORE_OVERRIDE && BAND_OVERRIDE);
endmodule
bind pdv_regs pdv_regs_props i_props (.*);

// ### test/pdv_regs_test.sv
`timescale 1ns/100ps
module pdv_regs_test;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [2:0]  ovr = 3'h0;
    logic [13:0] cal = 14'h0;
    logic [7:0]  addr, wdata, rdata, cp, d, band;
    logic        wr, rd, rvalid, auto_en, dbl, legal;
    logic [3:0]  caldiv, outdiv, bias;
    logic [5:0]  refdiv;
    logic [11:0] fb;
    logic [1:0]  core;
    int          err_total = 0;
    int          compares = 0;
    always #5 clk = ~clk;
    pdv_host i_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    pdv_regs i_dut (.SYS_CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .CORE_OVERRIDE(ovr[0]), .BIAS_OVERRIDE(ovr[1]),
        .BAND_OVERRIDE(ovr[2]), .CAL_CORE(cal[13:12]), .CAL_BIAS(cal[11:8]), .CAL_BAND(cal[7:0]),
        .AUTO_CALIBRATION_ENABLE(auto_en), .REFERENCE_DOUBLER_SELECT(dbl), .CAL_CLOCK_DIVIDER(caldiv),
        .OUTPUT_DIVIDER_SELECT(outdiv), .REF_DIVIDE(refdiv), .FEEDBACK_DIVIDE(fb), .FEEDBACK_DIVIDE_LEGAL(legal),
        .VCO_CORE(core), .VCO_BIAS(bias), .VCO_BAND(band), .CHARGE_PUMP_SETTINGS(cp));
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.rd_reg(a, d);
        chk("readback", 12'(e), 12'(d));
    endtask
    task automatic t_reset;
        logic [7:0] rv [6] = '{8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) rchk(8'h10 + 8'(i), rv[i]);
        chk("fb", 12'h080, fb);
        chk("ratios", 12'h111, {caldiv, outdiv, 3'h0, legal});
        chk("refdiv", 12'h001, 12'(refdiv));
        $display("t_reset done");
    endtask
    task automatic t_cal;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            i_host.wr_reg(8'h11, {~c[0], c[1], c, 4'h3});
            @(negedge clk);
            chk("ctrl", 12'({~c[0], c[1]}), 12'({auto_en, dbl}));
            chk("caldiv", 12'(4'h1 << c), 12'(caldiv));
            chk("fb held", 12'h080, fb);
        end
        $display("t_cal done");
    endtask
    task automatic t_fb;
        logic [11:0] v [3] = '{12'hABC, 12'h002, 12'hFFF};
        foreach (v[i]) begin
            i_host.wr_reg(8'h11, {4'h0, v[i][11:8]});
            chk("fb held", i ? v[i-1] : 12'h080, fb);
            i_host.wr_reg(8'h10, v[i][7:0]);
            @(negedge clk);
            chk("fb", v[i], fb);
            chk("legal", 12'h001, 12'(legal));
            rchk(8'h11, {4'h0, v[i][11:8]});
        end
        $display("t_fb done");
    endtask
    task automatic t_div;
        for (int i = 0; i < 4; i++) begin
            i_host.wr_reg(8'h12, {2'(i), 6'h3F - 6'(i)});
            @(negedge clk);
            chk("outdiv", 12'(4'h1 << i), 12'(outdiv));
            chk("refdiv", 12'(6'h3F - 6'(i)), 12'(refdiv));
        end
        i_host.wr_reg(8'h15, 8'h5A);
        i_host.wr_reg(8'h16, 8'hFF);
        rchk(8'h16, 8'h00);
        rchk(8'h15, 8'h5A);
        chk("cp", 12'h05A, 12'(cp));
        $display("t_div done");
    endtask
    task automatic t_vco;
        i_host.wr_reg(8'h13, 8'hE9);
        i_host.wr_reg(8'h14, 8'h37);
        rchk(8'h13, 8'hE9);
        for (int m = 0; m < 8; m++) begin
            @(negedge clk);
            {ovr, cal} = {3'(m), 2'h1, 4'h4, 8'hC8 ^ 8'(m)};
            @(negedge clk);
            chk("core", m[0] ? 12'h2 : 12'h1, 12'(core));
            chk("bias", m[1] ? 12'h9 : 12'h4, 12'(bias));
            chk("band", m[2] ? 12'h37 : 12'(8'hC8 ^ 8'(m)), 12'(band));
        end
        $display("t_vco done");
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        results;
    end
    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        t_reset;
        t_cal;
        t_fb;
        t_div;
        t_vco;
        results;
    end
endmodule

// ### verilog/pdv_dbuf.sv
`timescale 1ns/100ps
// holding register for the active copy: the staged value input moves to it on commit
module pdv_dbuf (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [11:0] stage_value,
    input  wire logic        commit,
    output logic      [11:0] active_value
);
    logic [11:0] active_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            active_r <= pdv_pkg::RST_FB_DIV;
        end else if (commit) begin
            active_r <= stage_value;
        end
    end

    assign active_value = active_r;
endmodule

// ### verilog/pdv_pkg.sv
package pdv_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_FB_LOW         = 8'h10;
    localparam logic [7:0] ADDR_CAL_REF_FB_HI  = 8'h11;
    localparam logic [7:0] ADDR_OUT_REF_DIV    = 8'h12;
    localparam logic [7:0] ADDR_VCO_CORE_BIAS  = 8'h13;
    localparam logic [7:0] ADDR_VCO_BAND       = 8'h14;
    localparam logic [7:0] ADDR_CHARGE_PUMP    = 8'h15;

    // reset values
    localparam logic [7:0] RST_FB_LOW          = 8'h80;
    localparam logic [7:0] RST_CAL_REF_FB_HI   = 8'h00;
    localparam logic [7:0] RST_OUT_REF_DIV     = 8'h01;
    localparam logic [7:0] RST_VCO_CORE_BIAS   = 8'h00;
    localparam logic [7:0] RST_VCO_BAND        = 8'h00;
    localparam logic [7:0] RST_CHARGE_PUMP     = 8'h00;
    localparam logic [7:0] RST_READ_DATA       = 8'h00;

    // field positions in 0x11
    localparam int AUTO_CAL_BIT       = 7;
    localparam int REF_DOUBLER_BIT    = 6;
    localparam int CAL_DIV_MSB        = 5;
    localparam int CAL_DIV_LSB        = 4;
    localparam int FB_HI_MSB          = 3;
    localparam int FB_HI_LSB          = 0;
    // field positions in 0x12
    localparam int OUT_DIV_MSB        = 7;
    localparam int OUT_DIV_LSB        = 6;
    localparam int REF_DIV_MSB        = 5;
    localparam int REF_DIV_LSB        = 0;
    // field positions in 0x13
    localparam int CORE_MSB           = 5;
    localparam int CORE_LSB           = 4;
    localparam int BIAS_MSB           = 3;
    localparam int BIAS_LSB           = 0;

    // legal feedback divide range
    localparam logic [11:0] FB_DIV_MIN = 12'h002;
    localparam logic [11:0] FB_DIV_MAX = 12'hFFF;
    localparam logic [11:0] RST_FB_DIV = {RST_CAL_REF_FB_HI[3:0], RST_FB_LOW};

    typedef struct packed {
        logic [1:0] core;
        logic [3:0] bias;
        logic [7:0] band;
    } pdv_vco_type;

    localparam pdv_vco_type RST_VCO = '{core: 2'h0, bias: 4'h0, band: 8'h00};

    // 2-bit code to one-hot power-of-two ratio: 00->1, 01->2, 10->4, 11->8
    function automatic logic [3:0] pow2_ratio(input logic [1:0] code);
        case (code)
            2'h0:    pow2_ratio = 4'h1;
            2'h1:    pow2_ratio = 4'h2;
            2'h2:    pow2_ratio = 4'h4;
            default: pow2_ratio = 4'h8;
        endcase
    endfunction

endpackage

// ### verilog/pdv_regs.sv
`timescale 1ns/100ps
module pdv_regs (
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    output logic             REG_RVALID,
    input  wire logic        CORE_OVERRIDE,
    input  wire logic        BIAS_OVERRIDE,
    input  wire logic        BAND_OVERRIDE,
    input  wire logic [1:0]  CAL_CORE,
    input  wire logic [3:0]  CAL_BIAS,
    input  wire logic [7:0]  CAL_BAND,
    output logic             AUTO_CALIBRATION_ENABLE,
    output logic             REFERENCE_DOUBLER_SELECT,
    output logic      [3:0]  CAL_CLOCK_DIVIDER,
    output logic      [3:0]  OUTPUT_DIVIDER_SELECT,
    output logic      [5:0]  REF_DIVIDE,
    output logic      [11:0] FEEDBACK_DIVIDE,
    output logic             FEEDBACK_DIVIDE_LEGAL,
    output logic      [1:0]  VCO_CORE,
    output logic      [3:0]  VCO_BIAS,
    output logic      [7:0]  VCO_BAND,
    output logic      [7:0]  CHARGE_PUMP_SETTINGS
);
    logic [7:0]  fb_low_r;
    logic [7:0]  cal_ref_fb_hi_r;
    logic [7:0]  out_ref_div_r;
    logic [7:0]  vco_core_bias_r;
    logic [7:0]  vco_band_r;
    logic [7:0]  charge_pump_r;
    logic [7:0]  rdata_r;
    logic        rvalid_r;
    logic [3:0]  cal_div_r;
    logic [3:0]  out_div_r;
    logic        fb_legal_r;

    wire         wr_fb_low   = REG_WR && (REG_ADDR == pdv_pkg::ADDR_FB_LOW);
    wire         wr_cal_ref  = REG_WR && (REG_ADDR == pdv_pkg::ADDR_CAL_REF_FB_HI);
    wire         wr_out_ref  = REG_WR && (REG_ADDR == pdv_pkg::ADDR_OUT_REF_DIV);
    wire         wr_core     = REG_WR && (REG_ADDR == pdv_pkg::ADDR_VCO_CORE_BIAS);
    wire         wr_band     = REG_WR && (REG_ADDR == pdv_pkg::ADDR_VCO_BAND);
    wire         wr_cp       = REG_WR && (REG_ADDR == pdv_pkg::ADDR_CHARGE_PUMP);

    // staged divide; the low byte write commits, so write 0x11 before 0x10
    wire  [11:0] fb_staged   = {cal_ref_fb_hi_r[pdv_pkg::FB_HI_MSB:pdv_pkg::FB_HI_LSB], fb_low_r};
    wire  [11:0] fb_commit_v = wr_fb_low ? {fb_staged[11:8], REG_WDATA} : fb_staged;
    wire  [11:0] fb_active;

    wire  [7:0]  rd_mux =
        (REG_ADDR == pdv_pkg::ADDR_FB_LOW)        ? fb_low_r        :
        (REG_ADDR == pdv_pkg::ADDR_CAL_REF_FB_HI) ? cal_ref_fb_hi_r :
        (REG_ADDR == pdv_pkg::ADDR_OUT_REF_DIV)   ? out_ref_div_r   :
        (REG_ADDR == pdv_pkg::ADDR_VCO_CORE_BIAS) ? vco_core_bias_r :
        (REG_ADDR == pdv_pkg::ADDR_VCO_BAND)      ? vco_band_r      :
        (REG_ADDR == pdv_pkg::ADDR_CHARGE_PUMP)   ? charge_pump_r   :
                                                    pdv_pkg::RST_READ_DATA;

    pdv_pkg::pdv_vco_type manual_vco;
    pdv_pkg::pdv_vco_type cal_vco;
    pdv_pkg::pdv_vco_type sel_vco;

    // codes pass straight through: 00 lowest core, band 0 highest band
    assign manual_vco.core = vco_core_bias_r[pdv_pkg::CORE_MSB:pdv_pkg::CORE_LSB];
    assign manual_vco.bias = vco_core_bias_r[pdv_pkg::BIAS_MSB:pdv_pkg::BIAS_LSB];
    assign manual_vco.band = vco_band_r;
    assign cal_vco.core    = CAL_CORE;
    assign cal_vco.bias    = CAL_BIAS;
    assign cal_vco.band    = CAL_BAND;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            fb_low_r        <= pdv_pkg::RST_FB_LOW;
            cal_ref_fb_hi_r <= pdv_pkg::RST_CAL_REF_FB_HI;
            out_ref_div_r   <= pdv_pkg::RST_OUT_REF_DIV;
            vco_core_bias_r <= pdv_pkg::RST_VCO_CORE_BIAS;
            vco_band_r      <= pdv_pkg::RST_VCO_BAND;
            charge_pump_r   <= pdv_pkg::RST_CHARGE_PUMP;
        end else begin
            if (wr_fb_low)  fb_low_r        <= REG_WDATA;
            if (wr_cal_ref) cal_ref_fb_hi_r <= REG_WDATA;
            if (wr_out_ref) out_ref_div_r   <= REG_WDATA;
            if (wr_core)    vco_core_bias_r <= REG_WDATA;
            if (wr_band)    vco_band_r      <= REG_WDATA;
            if (wr_cp)      charge_pump_r   <= REG_WDATA;
        end
    end

    // read answers one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rdata_r  <= pdv_pkg::RST_READ_DATA;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= REG_RD ? rd_mux : rdata_r;
            rvalid_r <= REG_RD;
        end
    end

    // decoded ratios registered so outputs come from flops
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            cal_div_r  <= pdv_pkg::pow2_ratio(pdv_pkg::RST_CAL_REF_FB_HI[pdv_pkg::CAL_DIV_MSB:pdv_pkg::CAL_DIV_LSB]);
            out_div_r  <= pdv_pkg::pow2_ratio(pdv_pkg::RST_OUT_REF_DIV[pdv_pkg::OUT_DIV_MSB:pdv_pkg::OUT_DIV_LSB]);
            fb_legal_r <= 1'b1;
        end else begin
            cal_div_r  <= pdv_pkg::pow2_ratio(cal_ref_fb_hi_r[pdv_pkg::CAL_DIV_MSB:pdv_pkg::CAL_DIV_LSB]);
            out_div_r  <= pdv_pkg::pow2_ratio(out_ref_div_r[pdv_pkg::OUT_DIV_MSB:pdv_pkg::OUT_DIV_LSB]);
            // flags a host that broke the 2..4095 range; the value is still used
            fb_legal_r <= (fb_active >= pdv_pkg::FB_DIV_MIN) && (fb_active <= pdv_pkg::FB_DIV_MAX);
        end
    end

    pdv_dbuf u_fb_dbuf (
        .clk          (SYS_CLK),
        .srst         (SRST),
        .stage_value  (fb_commit_v),
        .commit       (wr_fb_low),
        .active_value (fb_active)
    );

    pdv_vco_sel u_vco_sel (
        .clk           (SYS_CLK),
        .srst          (SRST),
        .manual        (manual_vco),
        .cal_result    (cal_vco),
        .core_override (CORE_OVERRIDE),
        .bias_override (BIAS_OVERRIDE),
        .band_override (BAND_OVERRIDE),
        .selected      (sel_vco)
    );

    assign REG_RDATA                = rdata_r;
    assign REG_RVALID               = rvalid_r;
    assign AUTO_CALIBRATION_ENABLE  = cal_ref_fb_hi_r[pdv_pkg::AUTO_CAL_BIT];
    assign REFERENCE_DOUBLER_SELECT = cal_ref_fb_hi_r[pdv_pkg::REF_DOUBLER_BIT];
    assign CAL_CLOCK_DIVIDER        = cal_div_r;
    assign OUTPUT_DIVIDER_SELECT    = out_div_r;
    assign REF_DIVIDE               = out_ref_div_r[pdv_pkg::REF_DIV_MSB:pdv_pkg::REF_DIV_LSB];
    assign FEEDBACK_DIVIDE          = fb_active;
    assign FEEDBACK_DIVIDE_LEGAL    = fb_legal_r;
    assign VCO_CORE                 = sel_vco.core;
    assign VCO_BIAS                 = sel_vco.bias;
    assign VCO_BAND                 = sel_vco.band;
    assign CHARGE_PUMP_SETTINGS     = charge_pump_r;
endmodule

// ### verilog/pdv_vco_sel.sv
`timescale 1ns/100ps
// registered choice between manual settings and calibration result
module pdv_vco_sel (
    input  wire logic                clk,
    input  wire logic                srst,
    input  pdv_pkg::pdv_vco_type     manual,
    input  pdv_pkg::pdv_vco_type     cal_result,
    input  wire logic                core_override,
    input  wire logic                bias_override,
    input  wire logic                band_override,
    output pdv_pkg::pdv_vco_type     selected
);
    pdv_pkg::pdv_vco_type sel_r;
    pdv_pkg::pdv_vco_type sel_nxt;

    assign sel_nxt.core = core_override ? manual.core : cal_result.core;
    assign sel_nxt.bias = bias_override ? manual.bias : cal_result.bias;
    assign sel_nxt.band = band_override ? manual.band : cal_result.band;

    always_ff @(posedge clk) begin
        if (srst) begin
            sel_r <= pdv_pkg::RST_VCO;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    assign selected = sel_r;
endmodule
